// File: verilog/adc_serial_pkg.sv
// Constants, register map and helpers for the octal serial converter core.
// Assumes a 10 MHz sample clock and a separate bit-rate link clock.
package adc_serial_pkg;

  // ****************************************
  // Word and channel geometry
  // ****************************************
  localparam int WORD_BITS   = 12;
  localparam int CHANNELS    = 8;
  localparam int HALF_STAGES = 13;
  localparam int POS_STAGES  = HALF_STAGES / 2;
  localparam int FRAME_HIGH  = WORD_BITS / 2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int MCLK_HZ           = 10_000_000;
  localparam int SETTLE_MS         = 100;
  localparam int SETTLE_CYCLES_DEF = SETTLE_MS * (MCLK_HZ / 1000);

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_ADDR   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] WORDS_ADDR  = 8'h08;
  localparam logic [ADDR_W-1:0] SNAP_BASE   = 8'h20;

  localparam int CTRL_FMT_BIT  = 0;
  localparam int CTRL_TEST_BIT = 1;
  localparam int CTRL_PD_BIT   = 2;
  localparam int CTRL_W        = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

  localparam int STAT_PD_BIT      = 0;
  localparam int STAT_SETTLED_BIT = 1;
  localparam int STAT_RANGE_OK    = 2;
  localparam int STAT_RANGE_LSB   = 3;
  localparam int STAT_TEST_BIT    = 6;
  localparam int STAT_FMT_BIT     = 7;

  // ****************************************
  // Codes
  // ****************************************
  localparam logic [WORD_BITS-1:0] TEST_WORD    = 12'h0BD;
  localparam logic [2:0]           RANGE_UNUSED = 3'h0;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_WAIT = 2'b01,
    LINK_RUN  = 2'b11
  } link_state_type;

  // Offset binary to two's complement: mid-scale 0x800 becomes 0x000
  function automatic logic [WORD_BITS-1:0] to_twos(
    input logic [WORD_BITS-1:0] code
  );
    to_twos = {~code[WORD_BITS-1], code[WORD_BITS-2:0]};
  endfunction : to_twos

endpackage : adc_serial_pkg

// File: verilog/adc_link_serializer.sv
// Link-side serializer: one lane per channel, frame and forwarded clock.
// Assumes link_clk runs at twelve times the word rate (one bit per edge
// of the forwarded clock); words arrive through a double bank.
`timescale 1ns/1ns
module adc_link_serializer #(
  parameter int CHANNELS  = adc_serial_pkg::CHANNELS,
  parameter int WORD_BITS = adc_serial_pkg::WORD_BITS
) (
  // Clock and reset
  input  wire logic                          link_clk,
  input  wire logic                          rst,
  // From the sample domain
  input  wire logic [CHANNELS*WORD_BITS-1:0] bank0,
  input  wire logic [CHANNELS*WORD_BITS-1:0] bank1,
  input  wire logic                          bank_toggle,
  input  wire logic                          pd_level,
  // Link pins
  output logic                               fwd_clock_pos,
  output logic                               fwd_clock_neg,
  output logic                               word_marker_pos,
  output logic                               word_marker_neg,
  output logic [CHANNELS-1:0]                lane_pos,
  output logic [CHANNELS-1:0]                lane_neg
);

  // ****************************************
  // Crossings
  // ****************************************
  logic tog_meta, tog_sync, tog_seen, pd_meta, pd_sync;
  adc_serial_pkg::link_state_type state;
  logic [3:0] bit_cnt;
  logic [CHANNELS*WORD_BITS-1:0] shreg, sel_bank;
  logic load, frame_next;

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      pd_meta  <= 1'b1;
      pd_sync  <= 1'b1;
    end else begin
      tog_meta <= bank_toggle;
      tog_sync <= tog_meta;
      pd_meta  <= pd_level;
      pd_sync  <= pd_meta;
    end
  end

  // Bank named by the synced toggle is not rewritten for two sample clocks
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      tog_seen <= 1'b0;
    end else begin
      tog_seen <= tog_sync;
    end
  end

  // ****************************************
  // Word sequencing
  // ****************************************
  assign load = (state == adc_serial_pkg::LINK_WAIT
                 && tog_sync != tog_seen)
             || (state == adc_serial_pkg::LINK_RUN
                 && bit_cnt == 4'(WORD_BITS - 1));
  assign sel_bank   = tog_sync ? bank1 : bank0;
  assign frame_next = load
    || (bit_cnt + 4'h1 < 4'(adc_serial_pkg::FRAME_HIGH));

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      state   <= adc_serial_pkg::LINK_IDLE;
      bit_cnt <= 4'h0;
    end else if (pd_sync) begin
      state   <= adc_serial_pkg::LINK_IDLE;
      bit_cnt <= 4'h0;
    end else begin
      case (state)
        adc_serial_pkg::LINK_IDLE: state <= adc_serial_pkg::LINK_WAIT;
        adc_serial_pkg::LINK_WAIT: begin
          if (load) begin
            state <= adc_serial_pkg::LINK_RUN;
          end
        end
        adc_serial_pkg::LINK_RUN: begin
          bit_cnt <= load ? 4'h0 : bit_cnt + 4'h1;
        end
        default: state <= adc_serial_pkg::LINK_IDLE;
      endcase
    end
  end

  // ****************************************
  // Lanes and frame
  // ****************************************
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      shreg           <= '0;
      lane_pos        <= '0;
      lane_neg        <= '0;
      word_marker_pos <= 1'b0;
      word_marker_neg <= 1'b0;
    end else if (state != adc_serial_pkg::LINK_RUN && !load) begin
      lane_pos        <= '0;
      lane_neg        <= '0;
      word_marker_pos <= 1'b0;
      word_marker_neg <= 1'b0;
    end else begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        if (load) begin
          lane_pos[ch] <= sel_bank[ch*WORD_BITS];
          lane_neg[ch] <= ~sel_bank[ch*WORD_BITS];
          shreg[ch*WORD_BITS +: WORD_BITS] <=
            sel_bank[ch*WORD_BITS +: WORD_BITS] >> 1;
        end else begin
          lane_pos[ch] <= shreg[ch*WORD_BITS];
          lane_neg[ch] <= ~shreg[ch*WORD_BITS];
          shreg[ch*WORD_BITS +: WORD_BITS] <=
            shreg[ch*WORD_BITS +: WORD_BITS] >> 1;
        end
      end
      // High for D0..D5, rising with D0, one period per word
      word_marker_pos <= frame_next;
      word_marker_neg <= !frame_next;
    end
  end

  // Falling-edge toggle puts forwarded edges mid-bit for the receiver
  always_ff @(negedge link_clk or posedge rst) begin
    if (rst) begin
      fwd_clock_pos <= 1'b0;
      fwd_clock_neg <= 1'b0;
    end else if (state == adc_serial_pkg::LINK_RUN) begin
      fwd_clock_pos <= ~fwd_clock_pos;
      fwd_clock_neg <= fwd_clock_pos;
    end else begin
      fwd_clock_pos <= 1'b0;
      fwd_clock_neg <= 1'b0;
    end
  end

endmodule : adc_link_serializer

// File: verilog/octal_adc_serial_output.sv
// Timing and serial output core of an eight-channel 12-bit converter.
// Assumes quantizer codes arrive as offset binary, synchronous to mclk,
// and a bit-rate link clock from an on-chip multiplier.
`timescale 1ns/1ns

// Function
// - Serial word for a sample appears 6.5 input clocks after sampling.
// - Samples advance one pipeline stage each half input clock period.
// - Eight channels share one clock, one frame, aligned samples.
// - Samples are taken on the rising input clock edge.
// - Forwarded clock derives from input clock multiplier, six times rate.
// - Data bits change half-way between forwarded clock edges, one bit per edge.
// - Frame rises together with bit D0 of each word.
// - Frame runs at the input clock rate, one period per word.
// - Words leave least significant bit first, D0 to D11.
// - Each channel has its own differential data lane.
// - Output words are offset binary or two's complement by select.
// - Select low gives two's complement, high gives offset binary.
// - Test pattern input replaces all lanes with word 0x0BD.
// - Power-down input stops all channels; low runs normally.
module octal_adc_serial_output #(
  parameter int CHANNELS      = adc_serial_pkg::CHANNELS,
  parameter int WORD_BITS     = adc_serial_pkg::WORD_BITS,
  parameter int SETTLE_CYCLES = adc_serial_pkg::SETTLE_CYCLES_DEF
) (
  // Clocks and reset
  input  wire logic                          mclk,
  input  wire logic                          link_clk,
  input  wire logic                          rst,
  // Quantizer codes, offset binary
  input  wire logic [CHANNELS*WORD_BITS-1:0] sample_in,
  // Static pins
  input  wire logic                          mult_range_sel_a,
  input  wire logic                          mult_range_sel_b,
  input  wire logic                          mult_range_sel_c,
  input  wire logic                          test_pattern_enable,
  input  wire logic                          power_down_in,
  // Avalon-MM slave
  input  wire logic [adc_serial_pkg::ADDR_W-1:0] address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [31:0]                   writedata,
  output logic      [31:0]                   readdata,
  output logic                               waitrequest,
  // Link pins
  output logic                               fwd_clock_pos,
  output logic                               fwd_clock_neg,
  output logic                               word_marker_pos,
  output logic                               word_marker_neg,
  output logic [CHANNELS-1:0]                lane_pos,
  output logic [CHANNELS-1:0]                lane_neg
);

  localparam int W = CHANNELS * WORD_BITS;

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (CHANNELS < 1 || CHANNELS > 8) begin : g_bad_channels
    $error("CHANNELS must be 1 to 8 for the snapshot map");
  end
  if (WORD_BITS != adc_serial_pkg::WORD_BITS) begin : g_bad_bits
    $error("WORD_BITS must match the serial word length");
  end
  if (SETTLE_CYCLES < 1) begin : g_bad_settle
    $error("SETTLE_CYCLES must be at least one");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] range_meta, range_sync;
  logic       test_meta, test_sync;
  logic       pd_meta, pd_sync;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      range_meta <= 3'h0;
      range_sync <= 3'h0;
      test_meta  <= 1'b0;
      test_sync  <= 1'b0;
      pd_meta    <= 1'b1;
      pd_sync    <= 1'b1;
    end else begin
      range_meta <= {mult_range_sel_a, mult_range_sel_b, mult_range_sel_c};
      range_sync <= range_meta;
      test_meta  <= test_pattern_enable;
      test_sync  <= test_meta;
      pd_meta    <= power_down_in;
      pd_sync    <= pd_meta;
    end
  end

  // ****************************************
  // Control register and derived levels
  // ****************************************
  logic [adc_serial_pkg::CTRL_W-1:0] ctrl;
  logic                              pd_level;
  logic                              test_level;
  logic                              fmt_binary;
  logic                              do_write;

  assign do_write = write && !waitrequest;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl <= adc_serial_pkg::CTRL_RESET;
    end else if (do_write && address == adc_serial_pkg::CTRL_ADDR) begin
      ctrl <= writedata[adc_serial_pkg::CTRL_W-1:0];
    end
  end

  // Registered so the link side never sees a combinational glitch
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pd_level   <= 1'b1;
      test_level <= 1'b0;
      fmt_binary <= 1'b0;
    end else begin
      pd_level   <= pd_sync
                  | ctrl[adc_serial_pkg::CTRL_PD_BIT];
      test_level <= test_sync
                  | ctrl[adc_serial_pkg::CTRL_TEST_BIT];
      fmt_binary <= ctrl[adc_serial_pkg::CTRL_FMT_BIT];
    end
  end

  // ****************************************
  // Reference settling monitor
  // ****************************************
  logic [31:0] settle_cnt;
  logic        settled;

  // Status only: data still flows before settling, as the pins demand
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      settle_cnt <= 32'h0;
      settled    <= 1'b0;
    end else if (pd_level) begin
      settle_cnt <= 32'h0;
      settled    <= 1'b0;
    end else if (settle_cnt == 32'(SETTLE_CYCLES - 1)) begin
      settled    <= 1'b1;
    end else begin
      settle_cnt <= settle_cnt + 32'h1;
    end
  end

  // ****************************************
  // Half-cycle pipeline
  // ****************************************
  // Alternate rising and falling stages: 13 half periods end to end
  logic [W-1:0] pos_stage [adc_serial_pkg::POS_STAGES];
  logic [W-1:0] neg_stage [adc_serial_pkg::POS_STAGES];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < adc_serial_pkg::POS_STAGES; k++) begin
        pos_stage[k] <= '0;
      end
    end else begin
      pos_stage[0] <= pd_level ? '0 : sample_in;
      for (int k = 1; k < adc_serial_pkg::POS_STAGES; k++) begin
        pos_stage[k] <= neg_stage[k-1];
      end
    end
  end

  always_ff @(negedge mclk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < adc_serial_pkg::POS_STAGES; k++) begin
        neg_stage[k] <= '0;
      end
    end else begin
      for (int k = 0; k < adc_serial_pkg::POS_STAGES; k++) begin
        neg_stage[k] <= pos_stage[k];
      end
    end
  end

  // ****************************************
  // Output coding
  // ****************************************
  logic [W-1:0] next_word;

  always_comb begin
    next_word = '0;
    for (int ch = 0; ch < CHANNELS; ch++) begin
      if (test_level) begin
        next_word[ch*WORD_BITS +: WORD_BITS] =
          adc_serial_pkg::TEST_WORD;
      end else if (fmt_binary) begin
        next_word[ch*WORD_BITS +: WORD_BITS] =
          neg_stage[adc_serial_pkg::POS_STAGES-1]
            [ch*WORD_BITS +: WORD_BITS];
      end else begin
        next_word[ch*WORD_BITS +: WORD_BITS] = adc_serial_pkg::to_twos(
          neg_stage[adc_serial_pkg::POS_STAGES-1]
            [ch*WORD_BITS +: WORD_BITS]);
      end
    end
  end

  // ****************************************
  // Hand-over banks to the link domain
  // ****************************************
  // Two banks: the one the link reads is untouched for two clocks,
  // so the wide word needs no per-bit synchroniser.
  logic [W-1:0] bank0, bank1;
  logic         bank_toggle;
  logic [31:0]  words_out;

  always_ff @(negedge mclk or posedge rst) begin
    if (rst) begin
      bank0       <= '0;
      bank1       <= '0;
      bank_toggle <= 1'b0;
      words_out   <= 32'h0;
    end else if (!pd_level) begin
      if (bank_toggle) begin
        bank0 <= next_word;
      end else begin
        bank1 <= next_word;
      end
      bank_toggle <= ~bank_toggle;
      words_out   <= words_out + 32'h1;
    end
  end

  // ****************************************
  // Link serializer
  // ****************************************
  adc_link_serializer #(
    .CHANNELS  (CHANNELS),
    .WORD_BITS (WORD_BITS)
  ) u_link (
    .link_clk        (link_clk),
    .rst             (rst),
    .bank0           (bank0),
    .bank1           (bank1),
    .bank_toggle     (bank_toggle),
    .pd_level        (pd_level),
    .fwd_clock_pos   (fwd_clock_pos),
    .fwd_clock_neg   (fwd_clock_neg),
    .word_marker_pos (word_marker_pos),
    .word_marker_neg (word_marker_neg),
    .lane_pos        (lane_pos),
    .lane_neg        (lane_neg)
  );

  // ****************************************
  // Register read path
  // ****************************************
  logic [31:0] next_readdata;
  logic [W-1:0] last_word;

  assign last_word = bank_toggle ? bank1 : bank0;

  always_comb begin
    next_readdata = 32'h0;
    case (address)
      adc_serial_pkg::CTRL_ADDR: begin
        next_readdata[adc_serial_pkg::CTRL_W-1:0] = ctrl;
      end
      adc_serial_pkg::STATUS_ADDR: begin
        next_readdata[adc_serial_pkg::STAT_PD_BIT]      = pd_level;
        next_readdata[adc_serial_pkg::STAT_SETTLED_BIT] = settled;
        next_readdata[adc_serial_pkg::STAT_RANGE_OK] =
          range_sync != adc_serial_pkg::RANGE_UNUSED;
        next_readdata[adc_serial_pkg::STAT_RANGE_LSB +: 3] = range_sync;
        next_readdata[adc_serial_pkg::STAT_TEST_BIT]    = test_level;
        next_readdata[adc_serial_pkg::STAT_FMT_BIT]     = fmt_binary;
      end
      adc_serial_pkg::WORDS_ADDR: begin
        next_readdata = words_out;
      end
      default: begin
        for (int ch = 0; ch < CHANNELS; ch++) begin
          if (address == adc_serial_pkg::SNAP_BASE
                         + adc_serial_pkg::ADDR_W'(4 * ch)) begin
            next_readdata[WORD_BITS-1:0] =
              last_word[ch*WORD_BITS +: WORD_BITS];
          end
        end
      end
    endcase
  end

  // ****************************************
  // Bus handshake
  // ****************************************
  // Fixed answer: waitrequest drops one clock after a request appears
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
      readdata    <= read ? next_readdata : 32'h0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

endmodule : octal_adc_serial_output

// File: sim/octal_adc_serial_output_props.sv
// Checker for the serial output core: framing, lanes and bus answer.
// Assumes it is bound into the core and sees only the core's ports.
`timescale 1ns/1ns
module octal_adc_serial_output_props #(
  parameter int CHANNELS = 8
) (
  // Clocks, reset and bus handshake
  input wire logic                mclk,
  input wire logic                link_clk,
  input wire logic                rst,
  input wire logic                read,
  input wire logic                write,
  input wire logic                waitrequest,
  // Static pins
  input wire logic                test_pattern_enable,
  input wire logic                power_down_in,
  // Link pins
  input wire logic                fwd_clock_pos,
  input wire logic                fwd_clock_neg,
  input wire logic                word_marker_pos,
  input wire logic                word_marker_neg,
  input wire logic [CHANNELS-1:0] lane_pos,
  input wire logic [CHANNELS-1:0] lane_neg
);
  localparam logic [CHANNELS-1:0] HI = '1;
  localparam logic [CHANNELS-1:0] LO = '0;
  // ****************************************
  // Hold counters
  // ****************************************
  // Pins reach the link late, so only long holds are judged
  logic [5:0] pd_cnt;
  logic [5:0] tp_cnt;
  logic       quiet;
  assign quiet = rst || power_down_in;
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      pd_cnt <= 6'h00;
      tp_cnt <= 6'h00;
    end else begin
      pd_cnt <= power_down_in ? pd_cnt + 6'(pd_cnt != 6'h3F) : 6'h00;
      tp_cnt <= test_pattern_enable ? tp_cnt + 6'(tp_cnt != 6'h3F) : 6'h00;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  sequence test_bits;
    lane_pos == HI ##1 lane_pos == LO ##1 lane_pos == HI ##1 lane_pos == HI
    ##1 lane_pos == HI ##1 lane_pos == HI ##1 lane_pos == LO
    ##1 lane_pos == HI ##1 lane_pos == LO [*4];
  endsequence
  AST_BUS_ANSWER: assert property (@(posedge mclk) disable iff (rst)
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle");
  AST_LANE_DIFF: assert property (@(posedge link_clk) disable iff (rst)
    word_marker_pos |-> lane_neg == ~lane_pos)
    else $error("lane pair not inverse");
  AST_MARKER_DIFF: assert property (@(posedge link_clk) disable iff (rst)
    word_marker_pos |-> !word_marker_neg && fwd_clock_pos != fwd_clock_neg)
    else $error("marker or clock pair not inverse");
  AST_FRAME_HIGH: assert property (@(posedge link_clk)
    disable iff (quiet)
    $rose(word_marker_pos) |-> word_marker_pos [*6] ##1 !word_marker_pos)
    else $error("marker high time wrong");
  AST_FRAME_LOW: assert property (@(posedge link_clk)
    disable iff (quiet)
    $fell(word_marker_pos) |-> !word_marker_pos [*6])
    else $error("marker low too short");
  AST_FWD_TOGGLE: assert property (@(posedge link_clk)
    disable iff (quiet)
    word_marker_pos && $past(word_marker_pos)
    |-> fwd_clock_pos != $past(fwd_clock_pos))
    else $error("clock missed an edge");
  AST_PD_IDLE: assert property (@(posedge link_clk) disable iff (rst)
    pd_cnt == 6'h3F |-> !fwd_clock_pos && !word_marker_pos
    && lane_pos == LO && lane_neg == LO)
    else $error("link active in power down");
  AST_TEST_WORD: assert property (@(posedge link_clk)
    disable iff (quiet)
    $rose(word_marker_pos) && tp_cnt == 6'h3F |-> test_bits)
    else $error("test word wrong");
  COV_FRAME: cover property (@(posedge link_clk) $rose(word_marker_pos));
  COV_TEST: cover property (@(posedge link_clk)
    $rose(word_marker_pos) && tp_cnt == 6'h3F);
  COV_PD: cover property (@(posedge link_clk) pd_cnt == 6'h3F);
endmodule : octal_adc_serial_output_props

bind octal_adc_serial_output octal_adc_serial_output_props #(
  .CHANNELS(CHANNELS)
) props (
  .mclk(mclk), .link_clk(link_clk), .rst(rst), .read(read),
  .write(write), .waitrequest(waitrequest),
  .test_pattern_enable(test_pattern_enable),
  .power_down_in(power_down_in), .fwd_clock_pos(fwd_clock_pos),
  .fwd_clock_neg(fwd_clock_neg), .word_marker_pos(word_marker_pos),
  .word_marker_neg(word_marker_neg), .lane_pos(lane_pos),
  .lane_neg(lane_neg)
);

// File: sim/lane_receiver.sv
// Receiving logic model: takes every lane on both forwarded clock edges.
// Assumes frame and lanes change half-way between forwarded clock edges.
`timescale 1ns/1ns
module lane_receiver #(
  parameter int CHANNELS  = 8,
  parameter int WORD_BITS = 12
) (
  // Link pins
  input  wire logic                     fwd_clock_pos,
  input  wire logic                     word_marker_pos,
  input  wire logic [CHANNELS-1:0]      lane_pos,
  // Assembled words
  output logic [CHANNELS*WORD_BITS-1:0] words,
  output int unsigned                   word_count
);
  logic [CHANNELS*WORD_BITS-1:0] shift       = '0;
  logic                          last_marker = 1'b0;
  int                            bit_idx     = WORD_BITS;
  initial begin
    words = '0;
    word_count = 0;
  end
  always @(posedge fwd_clock_pos or negedge fwd_clock_pos) begin
    if (word_marker_pos === 1'b1 && !last_marker) begin
      bit_idx = 0;
    end
    last_marker = (word_marker_pos === 1'b1);
    if (bit_idx < WORD_BITS) begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        shift[ch*WORD_BITS+bit_idx] = lane_pos[ch];
      end
      bit_idx++;
      if (bit_idx == WORD_BITS) begin
        words = shift;
        word_count++;
      end
    end
  end
endmodule : lane_receiver

// File: sim/tb.sv
// Testbench for the serial output core: bus tasks and link word checks.
// Assumes a free link clock of 32 ns and the receiver model on the lanes.
`timescale 1ns/1ns
module tb;
  localparam int CH = adc_serial_pkg::CHANNELS;
  localparam int WB = adc_serial_pkg::WORD_BITS;
  localparam logic [7:0] ST = adc_serial_pkg::STATUS_ADDR;
  localparam logic [7:0] CT = adc_serial_pkg::CTRL_ADDR;
  logic mclk, link_clk, rst, read, write, waitrequest;
  logic mult_range_sel_a, mult_range_sel_b, mult_range_sel_c;
  logic test_pattern_enable, power_down_in;
  logic fwd_clock_pos, fwd_clock_neg, word_marker_pos, word_marker_neg;
  logic [CH-1:0]    lane_pos, lane_neg;
  logic [CH*WB-1:0] sample_in, rx_words;
  logic [7:0]       address;
  logic [31:0]      writedata, readdata, rd;
  int unsigned      rx_count, cnt;
  int               fail_count, n_checks;

  octal_adc_serial_output #(.SETTLE_CYCLES(20)) dut (
    .mclk(mclk), .link_clk(link_clk), .rst(rst), .sample_in(sample_in),
    .mult_range_sel_a(mult_range_sel_a), .mult_range_sel_b(mult_range_sel_b),
    .mult_range_sel_c(mult_range_sel_c),
    .test_pattern_enable(test_pattern_enable), .power_down_in(power_down_in),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .fwd_clock_pos(fwd_clock_pos), .fwd_clock_neg(fwd_clock_neg),
    .word_marker_pos(word_marker_pos), .word_marker_neg(word_marker_neg),
    .lane_pos(lane_pos), .lane_neg(lane_neg));
  lane_receiver #(.CHANNELS(CH), .WORD_BITS(WB)) rx (
    .fwd_clock_pos(fwd_clock_pos), .word_marker_pos(word_marker_pos),
    .lane_pos(lane_pos), .words(rx_words), .word_count(rx_count));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Odd offset keeps the link phase unrelated to mclk
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    bit done;
    @(posedge mclk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    i = 0;
    do begin
      @(negedge mclk);
      done = (waitrequest === 1'b0);
      rd = readdata;
      @(posedge mclk);
      i++;
    end while (!done && i < 50);
    if (!done) begin
      check(32'h1, 32'h0);
      test_done();
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rd_chk
  task set_samples(input logic [WB-1:0] base);
    logic [CH*WB-1:0] v;
    for (int ch = 0; ch < CH; ch++) begin
      v[ch*WB+:WB] = base + WB'(ch * 12'h111);
    end
    sample_in <= v;
  endtask : set_samples
  // Mode 0 two's complement, 1 offset binary, 2 test word
  task expect_link(input int mode);
    logic [WB-1:0] s;
    int i;
    repeat (12) @(posedge mclk);
    cnt = rx_count;
    i = 0;
    while (rx_count < cnt + 4 && i < 2000) begin
      @(posedge link_clk);
      i++;
    end
    if (i >= 2000) begin
      check(32'h1, 32'h0);
      test_done();
    end
    for (int ch = 0; ch < CH; ch++) begin
      s = sample_in[ch*WB+:WB];
      if (mode == 0) s = s ^ 12'h800;
      if (mode == 2) s = 12'h0BD;
      check(32'(rx_words[ch*WB+:WB]), 32'(s));
    end
  endtask : expect_link
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    fail_count = 0;
    n_checks = 0;
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    {mult_range_sel_a, mult_range_sel_b, mult_range_sel_c} = 3'b101;
    test_pattern_enable = 1'b0;
    power_down_in = 1'b0;
    sample_in = '0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    set_samples(12'h800);
    repeat (40) @(posedge mclk);
    rd_chk(CT, 32'h0);
    rd_chk(ST, 32'h2E);
    rd_chk(8'h10, 32'h0);
    bus(1'b1, ST, 32'hFFFFFFFF);
    rd_chk(ST, 32'h2E);
    expect_link(0);
    rd_chk(adc_serial_pkg::SNAP_BASE + 8'h04, 32'h111);
    bus(1'b1, CT, 32'h1);
    rd_chk(CT, 32'h1);
    rd_chk(ST, 32'hAE);
    expect_link(1);
    set_samples(12'hEEF);
    expect_link(1);
    test_pattern_enable <= 1'b1;
    expect_link(2);
    test_pattern_enable <= 1'b0;
    bus(1'b1, CT, 32'h2);
    expect_link(2);
    bus(1'b1, CT, 32'h0);
    expect_link(0);
    power_down_in <= 1'b1;
    repeat (40) @(posedge mclk);
    bus(1'b0, ST, 32'h0);
    check(rd & 32'h1, 32'h1);
    cnt = rx_count;
    repeat (100) @(posedge link_clk);
    check(rx_count - cnt, 32'h0);
    check(32'(lane_pos), 32'h0);
    @(posedge mclk);
    power_down_in <= 1'b0;
    repeat (6) @(posedge mclk);
    bus(1'b0, ST, 32'h0);
    check(rd & 32'h2, 32'h0);
    repeat (40) @(posedge mclk);
    bus(1'b0, ST, 32'h0);
    check(rd & 32'h2, 32'h2);
    expect_link(0);
    test_done();
  end
endmodule : tb
